// ---- design/pdm_status_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// - status register zero bit 7 shows channel one powered, reset 0
// - status register zero bit 6 shows channel two powered, reset 0
// - status register one bits 7-5 hold mode, reset 4 meaning sleep
// - active with every channel off reads mode 6
// - active with any channel on reads mode 7
// - eight-bit checksum at 0x7E; a write loads the written value
// - every write to any other register on any page updates checksum
// - page select register at offset zero, reset 0, picks the page
// - all eight page bits select pages 0 through 255 directly
// - auto power policy field bits 7-6 decodes user or event control
// - bits 5-4 choose the monitored channel, reset selects channel 3
// - bits 3-2 choose oscillator, bit clock or master clock
// - clock select 3 hands detection clock to main clocking setup
// - bits 1-0 give external detection clock rate, 3.072 to 18.432 MHz
// - second detection register at page one 0x1F, reset 0x08
// - detection runs only while power register bit 0 is set
// - power bit 6 powers enabled channels up while sleep bit is clear, clearing powers all down
// - data pin carries detection interrupt when enabled and not recording
module pdm_status_regs
  import pdm_status_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  input  wire logic       CE,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       VOICE_START,
  input  wire logic       VOICE_END,
  output logic            DATA_IRQ_OUT,
  output logic            DATA_IRQ_OE,
  output logic [3:0]      CH_POWERED,
  output logic            DETECT_ENABLE,
  output logic [1:0]      DETECT_CHANNEL,
  output logic [1:0]      DETECT_CLK_SOURCE,
  output logic            DETECT_CLK_CUSTOM,
  output logic [1:0]      DETECT_EXT_RATE,
  output logic            DETECT_DURING_REC,
  output logic            MICBIAS_ON,
  output logic            PLL_ON
);

  // ----------------------------------------------------------------
  // decode helper
  // ----------------------------------------------------------------
  function automatic logic at(input logic [7:0] pg, input logic [7:0] ofs,
                              input logic [7:0] want_pg, input logic [7:0] want_ofs);
    at = (pg == want_pg) && (ofs == want_ofs);
  endfunction : at

  // ----------------------------------------------------------------
  // control bus engine
  // ----------------------------------------------------------------
  bus_state_t st_q;
  bus_state_t st_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] shf_q;
  logic [7:0] shf_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic       oe_q;
  logic       oe_d;
  logic       scl_q;
  logic       sda_q;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [7:0] byte_in;
  logic       wr_stb;
  logic [7:0] rd_byte;

  // register state, declared early for the read mux
  logic [7:0]  page_q;
  logic [7:0]  page_d;
  logic        sleep_q;
  logic        sleep_d;
  logic [3:0]  ch_en_q;
  logic [3:0]  ch_en_d;
  power_cfg_t  pwr_q;
  power_cfg_t  pwr_d;
  detect_cfg_t vcfg_q;
  detect_cfg_t vcfg_d;
  logic        irq_mode_q;
  logic        irq_mode_d;
  logic        rec_det_q;
  logic        rec_det_d;
  logic [7:0]  cksum_q;
  logic [7:0]  cksum_d;
  logic        voice_q;
  logic        voice_d;
  logic        irq_oe_q;
  logic        irq_oe_d;
  logic        irq_out_q;
  logic        irq_out_d;
  logic        custom_q;
  logic        custom_d;
  logic [3:0]  ch_target;
  logic [3:0]  ch_powered;
  logic [2:0]  mode_state_field;

  // scl and sda are taken as synchronous, so one stage of history suffices
  always_comb begin
    rise    = !scl_q && SCL;
    fall    = scl_q && !SCL;
    start   = scl_q && SCL && sda_q && !SDA_IN;
    stop    = scl_q && SCL && !sda_q && SDA_IN;
    byte_in = {shf_q[6:0], SDA_IN};
  end

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    shf_d  = shf_q;
    ptr_d  = ptr_q;
    oe_d   = oe_q;
    wr_stb = 1'b0;
    if (stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      st_d  = ST_ADDR;
      cnt_d = 3'h0;
      oe_d  = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          st_d = ST_IDLE;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (rise) begin
            shf_d = byte_in;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              if (st_q == ST_ADDR) begin
                st_d = (shf_q[6:0] == DEV_ADDR) ? ST_AACK : ST_IDLE;
              end else if (st_q == ST_REG) begin
                ptr_d = byte_in;
                st_d  = ST_PACK;
              end else begin
                wr_stb = 1'b1;
                st_d   = ST_WACK;
              end
            end
          end
        end
        ST_AACK, ST_PACK, ST_WACK: begin
          // first fall drives the ack low, second fall releases it, or after a read address drives data bit 7
          if (fall) begin
            if (!oe_q) begin
              oe_d = 1'b1;
            end else begin
              oe_d  = 1'b0;
              cnt_d = 3'h0;
              if (st_q == ST_WACK) begin
                ptr_d = ptr_q + 8'h01;
                st_d  = ST_WDATA;
              end else if (st_q == ST_PACK) begin
                st_d = ST_WDATA;
              end else if (shf_q[0]) begin
                shf_d = rd_byte;
                oe_d  = !rd_byte[7];
                st_d  = ST_RDATA;
              end else begin
                st_d = ST_REG;
              end
            end
          end
        end
        ST_RDATA: begin
          if (rise) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              st_d = ST_MACK;
            end
          end else if (fall) begin
            shf_d = {shf_q[6:0], 1'b0};
            oe_d  = !shf_q[6];
          end
        end
        ST_MACK: begin
          if (fall) begin
            if (cnt_q == 3'h0 && oe_q == 1'b0 && shf_q == 8'h01) begin
              // controller acked: next byte from the advanced pointer
              shf_d = rd_byte;
              oe_d  = !rd_byte[7];
              st_d  = ST_RDATA;
            end else begin
              oe_d = 1'b0;
            end
          end else if (rise) begin
            if (!SDA_IN) begin
              ptr_d = ptr_q + 8'h01;
              shf_d = 8'h01;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_q  <= ST_IDLE;
      cnt_q <= 3'h0;
      shf_q <= 8'h00;
      ptr_q <= 8'h00;
      oe_q  <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (CE) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      shf_q <= shf_d;
      ptr_q <= ptr_d;
      oe_q  <= oe_d;
      scl_q <= SCL;
      sda_q <= SDA_IN;
    end
  end

  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = oe_q;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == OFS_PAGE) begin
      rd_byte = page_q;
    end else if (at(page_q, ptr_q, PAGE_MAIN, OFS_SLEEP)) begin
      rd_byte[SLEEP_BIT] = sleep_q;
    end else if (at(page_q, ptr_q, PAGE_MAIN, OFS_CH_EN)) begin
      rd_byte[CH_EN_LSB +: 4] = ch_en_q;
    end else if (at(page_q, ptr_q, PAGE_MAIN, OFS_PWR)) begin
      rd_byte[PWR_MICBIAS_BIT] = pwr_q.micbias;
      rd_byte[PWR_ADC_BIT]     = pwr_q.adc;
      rd_byte[PWR_PLL_BIT]     = pwr_q.pll;
      rd_byte[PWR_VAD_BIT]     = pwr_q.voice_detect_enable;
    end else if (at(page_q, ptr_q, PAGE_MAIN, OFS_STS0)) begin
      rd_byte[STS0_CH1_BIT] = ch_powered[0];
      rd_byte[STS0_CH2_BIT] = ch_powered[1];
    end else if (at(page_q, ptr_q, PAGE_MAIN, OFS_STS1)) begin
      rd_byte[STS1_MODE_LSB +: 3] = mode_state_field;
    end else if (at(page_q, ptr_q, PAGE_MAIN, OFS_CKSUM)) begin
      rd_byte = cksum_q;
    end else if (at(page_q, ptr_q, PAGE_VOICE, OFS_VCFG1)) begin
      rd_byte = vcfg_q;
    end else if (at(page_q, ptr_q, PAGE_VOICE, OFS_VCFG2)) begin
      rd_byte[VCFG2_IRQ_BIT] = irq_mode_q;
      rd_byte[VCFG2_REC_BIT] = rec_det_q;
    end
  end

  // ----------------------------------------------------------------
  // register writes and detection events
  // ----------------------------------------------------------------
  always_comb begin
    page_d     = page_q;
    sleep_d    = sleep_q;
    ch_en_d    = ch_en_q;
    pwr_d      = pwr_q;
    vcfg_d     = vcfg_q;
    irq_mode_d = irq_mode_q;
    rec_det_d  = rec_det_q;
    cksum_d    = cksum_q;
    voice_d    = voice_q;
    if (wr_stb) begin
      if (ptr_q == OFS_PAGE) begin
        page_d = byte_in;
      end
      if (at(page_q, ptr_q, PAGE_MAIN, OFS_SLEEP)) begin
        sleep_d = byte_in[SLEEP_BIT];
      end
      if (at(page_q, ptr_q, PAGE_MAIN, OFS_CH_EN)) begin
        ch_en_d = byte_in[CH_EN_LSB +: 4];
      end
      if (at(page_q, ptr_q, PAGE_MAIN, OFS_PWR)) begin
        pwr_d.micbias = byte_in[PWR_MICBIAS_BIT];
        pwr_d.adc     = byte_in[PWR_ADC_BIT];
        pwr_d.pll     = byte_in[PWR_PLL_BIT];
        pwr_d.voice_detect_enable  = byte_in[PWR_VAD_BIT];
      end
      if (at(page_q, ptr_q, PAGE_VOICE, OFS_VCFG1)) begin
        vcfg_d = detect_cfg_t'(byte_in);
      end
      if (at(page_q, ptr_q, PAGE_VOICE, OFS_VCFG2)) begin
        irq_mode_d = byte_in[VCFG2_IRQ_BIT];
        rec_det_d  = byte_in[VCFG2_REC_BIT];
      end
      // status registers have no write path at all
      if (at(page_q, ptr_q, PAGE_MAIN, OFS_CKSUM)) begin
        cksum_d = byte_in;
      end else begin
        cksum_d = cksum_q + byte_in;
      end
    end
    // detector events override a same-cycle host write to the power bit
    if (pwr_q.voice_detect_enable) begin
      if (VOICE_END) begin
        voice_d = 1'b0;
        if (vcfg_q.policy == POL_AUTO || vcfg_q.policy == POL_AUTO_DOWN) begin
          pwr_d.adc = 1'b0;
        end
      end
      if (VOICE_START) begin
        voice_d = 1'b1;
        if (vcfg_q.policy == POL_AUTO || vcfg_q.policy == POL_AUTO_UP) begin
          pwr_d.adc = 1'b1;
        end
      end
    end else begin
      voice_d = 1'b0;
    end
  end

  always_comb begin
    // enable field holds channel one at its msb, status vector at bit 0
    ch_target = (pwr_q.adc && !sleep_q) ?
                {ch_en_q[0], ch_en_q[1], ch_en_q[2], ch_en_q[3]} : 4'h0;
    irq_oe_d  = irq_mode_q && !(|ch_powered);
    irq_out_d = voice_q;
    custom_d  = (vcfg_d.clock_source_config == CLOCK_SOURCE_CONFIG_CUSTOM);
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      page_q     <= RST_PAGE;
      sleep_q    <= RST_SLEEP[SLEEP_BIT];
      ch_en_q    <= RST_CH_EN[CH_EN_LSB +: 4];
      pwr_q      <= '{micbias: RST_PWR[PWR_MICBIAS_BIT], adc: RST_PWR[PWR_ADC_BIT],
                      pll: RST_PWR[PWR_PLL_BIT], voice_detect_enable: RST_PWR[PWR_VAD_BIT]};
      vcfg_q     <= detect_cfg_t'(RST_VCFG1);
      irq_mode_q <= RST_VCFG2[VCFG2_IRQ_BIT];
      rec_det_q  <= RST_VCFG2[VCFG2_REC_BIT];
      cksum_q    <= RST_CKSUM;
      voice_q    <= 1'b0;
      irq_oe_q   <= 1'b0;
      irq_out_q  <= 1'b0;
      custom_q   <= 1'b0;
    end else if (CE) begin
      page_q     <= page_d;
      sleep_q    <= sleep_d;
      ch_en_q    <= ch_en_d;
      pwr_q      <= pwr_d;
      vcfg_q     <= vcfg_d;
      irq_mode_q <= irq_mode_d;
      rec_det_q  <= rec_det_d;
      cksum_q    <= cksum_d;
      voice_q    <= voice_d;
      irq_oe_q   <= irq_oe_d;
      irq_out_q  <= irq_out_d;
      custom_q   <= custom_d;
    end
  end

  // ----------------------------------------------------------------
  // power status tracking
  // ----------------------------------------------------------------
  power_status_track #(
    .N      (NUM_CH),
    .SETTLE (SETTLE_CYCLES)
  ) u_track (
    .clk       (CLOCK),
    .rst_n     (NRST),
    .ce        (CE),
    .sleep     (sleep_q),
    .target    (ch_target),
    .powered_q (ch_powered),
    .mode_q    (mode_state_field)
  );

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign CH_POWERED        = ch_powered;
  assign DATA_IRQ_OE       = irq_oe_q;
  assign DATA_IRQ_OUT      = irq_out_q;
  assign DETECT_ENABLE     = pwr_q.voice_detect_enable;
  assign DETECT_CHANNEL    = vcfg_q.chan;
  assign DETECT_CLK_SOURCE = vcfg_q.clock_source_config;
  assign DETECT_CLK_CUSTOM = custom_q;
  assign DETECT_EXT_RATE   = vcfg_q.ext_rate;
  assign DETECT_DURING_REC = rec_det_q;
  assign MICBIAS_ON        = pwr_q.micbias;
  assign PLL_ON            = pwr_q.pll;

endmodule : pdm_status_regs

// ---- design/pdm_status_pkg.sv ----
package pdm_status_pkg;

  // ----------------------------------------------------------------
  // register pages and offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_MAIN   = 8'h00;
  localparam logic [7:0] PAGE_VOICE  = 8'h01;
  localparam logic [7:0] OFS_PAGE    = 8'h00;
  localparam logic [7:0] OFS_SLEEP   = 8'h02;
  localparam logic [7:0] OFS_CH_EN   = 8'h73;
  localparam logic [7:0] OFS_PWR     = 8'h75;
  localparam logic [7:0] OFS_STS0    = 8'h76;
  localparam logic [7:0] OFS_STS1    = 8'h77;
  localparam logic [7:0] OFS_CKSUM   = 8'h7e;
  localparam logic [7:0] OFS_VCFG1   = 8'h1e;
  localparam logic [7:0] OFS_VCFG2   = 8'h1f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PAGE    = 8'h00;
  localparam logic [7:0] RST_SLEEP   = 8'h01;
  localparam logic [7:0] RST_CH_EN   = 8'hc0;
  localparam logic [7:0] RST_PWR     = 8'h00;
  localparam logic [7:0] RST_STS0    = 8'h00;
  localparam logic [7:0] RST_STS1    = 8'h80;
  localparam logic [7:0] RST_CKSUM   = 8'h00;
  localparam logic [7:0] RST_VCFG1   = 8'h20;
  localparam logic [7:0] RST_VCFG2   = 8'h08;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STS0_CH1_BIT    = 7;
  localparam int STS0_CH2_BIT    = 6;
  localparam int STS1_MODE_LSB   = 5;
  localparam int PWR_MICBIAS_BIT = 7;
  localparam int PWR_ADC_BIT     = 6;
  localparam int PWR_PLL_BIT     = 5;
  localparam int PWR_VAD_BIT     = 0;
  localparam int CH_EN_LSB       = 4;
  localparam int VCFG2_IRQ_BIT   = 6;
  localparam int VCFG2_REC_BIT   = 3;
  localparam int SLEEP_BIT       = 0;

  // ----------------------------------------------------------------
  // codes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SLEEP    = 3'h4;
  localparam logic [2:0] MODE_IDLE     = 3'h6;
  localparam logic [2:0] MODE_ACTIVE   = 3'h7;
  localparam logic [1:0] POL_USER      = 2'h0;
  localparam logic [1:0] POL_AUTO      = 2'h1;
  localparam logic [1:0] POL_AUTO_UP   = 2'h2;
  localparam logic [1:0] POL_AUTO_DOWN = 2'h3;
  localparam logic [1:0] CLOCK_SOURCE_CONFIG_OSC   = 2'h0;
  localparam logic [1:0] CLOCK_SOURCE_CONFIG_BIT   = 2'h1;
  localparam logic [1:0] CLOCK_SOURCE_CONFIG_MAIN  = 2'h2;
  localparam logic [1:0] CLOCK_SOURCE_CONFIG_CUSTOM = 2'h3;
  localparam int         NUM_CH        = 4;
  localparam int         SETTLE_CYCLES = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] policy;
    logic [1:0] chan;
    logic [1:0] clock_source_config;
    logic [1:0] ext_rate;
  } detect_cfg_t;

  typedef struct packed {
    logic micbias;
    logic adc;
    logic pll;
    logic voice_detect_enable;
  } power_cfg_t;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_REG   = 9'h008,
    ST_PACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_MACK  = 9'h100
  } bus_state_t;

endpackage : pdm_status_pkg

// ---- design/power_status_track.sv ----
`timescale 1ns/1ps
module power_status_track
  import pdm_status_pkg::*;
#(
  parameter int N      = NUM_CH,
  parameter int SETTLE = SETTLE_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         sleep,
  input  wire logic [N-1:0] target,
  output logic      [N-1:0] powered_q,
  output logic      [2:0]   mode_q
);

  // ----------------------------------------------------------------
  // settle counter: a channel is reported only after its power settles
  // ----------------------------------------------------------------
  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE - 1);

  logic [3:0]   cnt_q;
  logic [3:0]   cnt_d;
  logic [N-1:0] powered_d;
  logic [2:0]   mode_d;
  logic         take;

  always_comb begin
    take  = (cnt_q == SETTLE_LAST);
    cnt_d = 4'h0;
    if (target != powered_q && !take) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      always_comb begin
        powered_d[i] = take ? target[i] : powered_q[i];
      end
    end
  endgenerate

  always_comb begin
    if (sleep) begin
      mode_d = MODE_SLEEP;
    end else if (|powered_d) begin
      mode_d = MODE_ACTIVE;
    end else begin
      mode_d = MODE_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 4'h0;
      powered_q <= '0;
      mode_q    <= MODE_SLEEP;
    end else if (ce) begin
      cnt_q     <= cnt_d;
      powered_q <= powered_d;
      mode_q    <= mode_d;
    end
  end

endmodule : power_status_track

// ---- verif/pdm_status_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module pdm_status_properties
  import pdm_status_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       NRST,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic       VOICE_START,
  input wire logic       VOICE_END,
  input wire logic       DATA_IRQ_OUT,
  input wire logic       DATA_IRQ_OE,
  input wire logic [3:0] CH_POWERED,
  input wire logic       DETECT_ENABLE,
  input wire logic [1:0] DETECT_CHANNEL,
  input wire logic [1:0] DETECT_CLK_SOURCE,
  input wire logic       DETECT_CLK_CUSTOM,
  input wire logic [1:0] DETECT_EXT_RATE,
  input wire logic       DETECT_DURING_REC,
  input wire logic       MICBIAS_ON,
  input wire logic       PLL_ON
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_reset_values: assert property (!$past(NRST) |-> CH_POWERED == 4'h0
    && DETECT_CHANNEL == 2'h2 && DETECT_DURING_REC == 1'b1)
    else $error("outputs wrong after reset");
  a_settle_hold: assert property ($changed(CH_POWERED) |=> $stable(CH_POWERED)[*3])
    else $error("channel power changed before settling");
  // flag is registered from the next source value, so it never lags
  a_custom_clock: assert property (DETECT_CLK_CUSTOM ==
    (DETECT_CLK_SOURCE == CLOCK_SOURCE_CONFIG_CUSTOM))
    else $error("custom clock flag disagrees with source");
  a_irq_pin_idle: assert property (DATA_IRQ_OE |->
    (CH_POWERED == 4'h0 || $past(CH_POWERED) == 4'h0))
    else $error("interrupt pin driven while recording");
  a_voice_flag_set: assert property (DETECT_ENABLE && VOICE_START |-> ##[1:2] DATA_IRQ_OUT)
    else $error("voice flag not raised");
  a_voice_flag_clear: assert property (DETECT_ENABLE && VOICE_END && !VOICE_START
    |-> ##[1:2] !DATA_IRQ_OUT)
    else $error("voice flag not cleared");
  a_cfg_write_time: assert property ($changed({DETECT_CHANNEL, DETECT_CLK_SOURCE,
    DETECT_EXT_RATE}) |-> !SDA_OE)
    else $error("detect config changed while device drives the bus");
  a_power_write_time: assert property ($changed({MICBIAS_ON, PLL_ON, DETECT_ENABLE})
    |-> !SDA_OE)
    else $error("power config changed while device drives the bus");
  a_sda_pull_low: assert property (SDA_OUT == 1'b0)
    else $error("data line pull value not low");
endmodule : pdm_status_properties

bind pdm_status_regs pdm_status_properties u_pdm_status_properties (
  .CLOCK(CLOCK), .NRST(NRST), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .VOICE_START(VOICE_START), .VOICE_END(VOICE_END), .DATA_IRQ_OUT(DATA_IRQ_OUT),
  .DATA_IRQ_OE(DATA_IRQ_OE), .CH_POWERED(CH_POWERED), .DETECT_ENABLE(DETECT_ENABLE),
  .DETECT_CHANNEL(DETECT_CHANNEL), .DETECT_CLK_SOURCE(DETECT_CLK_SOURCE),
  .DETECT_CLK_CUSTOM(DETECT_CLK_CUSTOM), .DETECT_EXT_RATE(DETECT_EXT_RATE),
  .DETECT_DURING_REC(DETECT_DURING_REC), .MICBIAS_ON(MICBIAS_ON), .PLL_ON(PLL_ON));

// ---- verif/bus_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// control bus controller model
// ----------------------------------------------------------------
module bus_host_model #(
  parameter logic [6:0] ADDR = 7'h40
) (
  input  wire logic CLOCK,
  input  wire logic SDA,
  output logic      SCL,
  output logic      PULL
);
  initial begin
    SCL = 1'b1;
    PULL = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : hold
  // start also serves as repeated start: data released before clock rises
  task automatic start();
    PULL = 1'b0;
    hold(3);
    SCL = 1'b1;
    hold(4);
    PULL = 1'b1;
    hold(4);
    SCL = 1'b0;
    hold(3);
  endtask : start
  task automatic stop();
    PULL = 1'b1;
    hold(3);
    SCL = 1'b1;
    hold(4);
    PULL = 1'b0;
    hold(4);
  endtask : stop
  // data moves only mid low phase so the target never sees a false start
  task automatic bit_io(input logic b, output logic s);
    PULL = ~b;
    hold(3);
    SCL = 1'b1;
    hold(2);
    s = SDA;
    hold(2);
    SCL = 1'b0;
    hold(3);
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : xfer
  task automatic wr(input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, r, a0);
    xfer(ofs, r, a1);
    xfer(dat, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr
  // a read ends with a nack, so only one byte is taken each time
  task automatic rd(input logic [7:0] ofs, output logic [7:0] dat, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, r, a0);
    xfer(ofs, r, a1);
    start();
    xfer({ADDR, 1'b1}, r, a2);
    xfer(8'hff, dat, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : bus_host_model

// ---- verif/tb_pdm_status_regs.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register bank bench
// ----------------------------------------------------------------
module tb_pdm_status_regs;
  import pdm_status_pkg::*;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic       vstart = 1'b0;
  logic       vend = 1'b0;
  logic       scl, pull, sda_oe, irq_out, irq_oe, det_en, custom, rec, micbias, pll;
  logic [3:0] powered;
  logic [1:0] chan, src, rate;
  wire        sda = ~(pull | sda_oe);
  int         fails = 0;
  int         comparisons = 0;
  logic [7:0] ck = 8'h00;
  logic [7:0] page = 8'h00;
  logic [7:0] rdat;
  logic       ok;

  always #5 clock = ~clock;

  pdm_status_regs u_pdm_status_regs (
    .CLOCK(clock), .NRST(nrst), .CE(1'b1), .SCL(scl), .SDA_IN(sda), .SDA_OUT(),
    .SDA_OE(sda_oe), .VOICE_START(vstart), .VOICE_END(vend), .DATA_IRQ_OUT(irq_out),
    .DATA_IRQ_OE(irq_oe), .CH_POWERED(powered), .DETECT_ENABLE(det_en),
    .DETECT_CHANNEL(chan), .DETECT_CLK_SOURCE(src), .DETECT_CLK_CUSTOM(custom),
    .DETECT_EXT_RATE(rate), .DETECT_DURING_REC(rec), .MICBIAS_ON(micbias), .PLL_ON(pll));
  bus_host_model u_bus_host_model (.CLOCK(clock), .SDA(sda), .SCL(scl), .PULL(pull));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // the expected checksum is tracked here for every write the bench makes
  task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
    u_bus_host_model.wr(ofs, d, ok);
    check("write ack", {7'h0, ok}, 8'h01);
    ck = (page == PAGE_MAIN && ofs == OFS_CKSUM) ? d : ck + d;
    if (ofs == OFS_PAGE) page = d;
  endtask : wreg
  task automatic rreg(input string what, input logic [7:0] ofs, input logic [7:0] exp);
    u_bus_host_model.rd(ofs, rdat, ok);
    check("read ack", {7'h0, ok}, 8'h01);
    check(what, rdat, exp);
  endtask : rreg
  // twelve cycles covers the settle count plus the registered status
  task automatic pulse(input logic s);
    @(negedge clock);
    vstart = s;
    vend = ~s;
    @(negedge clock);
    vstart = 1'b0;
    vend = 1'b0;
    repeat (12) @(negedge clock);
  endtask : pulse
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    summarize();
  end

  initial begin
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    check("chan reset", {6'h0, chan}, 8'h02);
    rreg("sts0 reset", OFS_STS0, RST_STS0);
    rreg("sts1 reset", OFS_STS1, RST_STS1);
    rreg("cksum reset", OFS_CKSUM, RST_CKSUM);
    rreg("page reset", OFS_PAGE, RST_PAGE);
    wreg(OFS_PAGE, PAGE_VOICE);
    rreg("vcfg1 reset", OFS_VCFG1, RST_VCFG1);
    rreg("vcfg2 reset", OFS_VCFG2, RST_VCFG2);
    rreg("unlisted", 8'h10, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wreg(OFS_VCFG1, {4{i[1:0]}});
      check("chan", {6'h0, chan}, {6'h0, i[1:0]});
      check("src", {6'h0, src}, {6'h0, i[1:0]});
      check("custom", {7'h0, custom}, {7'h0, i == 3});
      check("rate", {6'h0, rate}, {6'h0, i[1:0]});
      rreg("vcfg1", OFS_VCFG1, {4{i[1:0]}});
    end
    wreg(OFS_PAGE, 8'hff);
    rreg("page 255", OFS_PAGE, 8'hff);
    rreg("page 255 empty", OFS_VCFG1, 8'h00);
    wreg(OFS_PAGE, PAGE_MAIN);
    wreg(OFS_SLEEP, 8'h00);
    rreg("idle mode", OFS_STS1, {MODE_IDLE, 5'h0});
    wreg(OFS_PWR, 8'h41);
    check("powered", {4'h0, powered}, 8'h03);
    check("detect en", {7'h0, det_en}, 8'h01);
    rreg("sts0 on", OFS_STS0, 8'hc0);
    rreg("active mode", OFS_STS1, {MODE_ACTIVE, 5'h0});
    wreg(OFS_STS0, 8'h00);
    wreg(OFS_STS1, 8'h00);
    rreg("sts0 ro", OFS_STS0, 8'hc0);
    rreg("sts1 ro", OFS_STS1, {MODE_ACTIVE, 5'h0});
    rreg("cksum sum", OFS_CKSUM, ck);
    wreg(OFS_CKSUM, 8'h5a);
    wreg(OFS_CH_EN, 8'hc0);
    rreg("cksum load", OFS_CKSUM, ck);
    for (int p = 0; p < 4; p++) begin
      wreg(OFS_PAGE, PAGE_VOICE);
      wreg(OFS_VCFG1, {p[1:0], 6'h20});
      wreg(OFS_PAGE, PAGE_MAIN);
      wreg(OFS_PWR, 8'h01);
      pulse(1'b1);
      check("event up", {4'h0, powered}, (p == 1 || p == 2) ? 8'h03 : 8'h00);
      check("voice set", {7'h0, irq_out}, 8'h01);
      wreg(OFS_PWR, 8'h41);
      pulse(1'b0);
      check("event down", {4'h0, powered}, (p == 1 || p == 3) ? 8'h00 : 8'h03);
      check("voice clear", {7'h0, irq_out}, 8'h00);
    end
    wreg(OFS_PWR, 8'h40);
    pulse(1'b0);
    check("events gated", {4'h0, powered}, 8'h03);
    wreg(OFS_PWR, 8'ha0);
    check("bias pll", {6'h0, micbias, pll}, 8'h03);
    wreg(OFS_PAGE, PAGE_VOICE);
    wreg(OFS_VCFG2, 8'h48);
    check("irq pin on", {7'h0, irq_oe}, 8'h01);
    rreg("vcfg2", OFS_VCFG2, 8'h48);
    wreg(OFS_PAGE, PAGE_MAIN);
    wreg(OFS_PWR, 8'h40);
    check("irq pin off", {7'h0, irq_oe}, 8'h00);
    rreg("cksum end", OFS_CKSUM, ck);
    summarize();
  end
endmodule : tb_pdm_status_regs
